// ### logic/mbmc_pkg.sv
// Purpose: shared constants and types for the buffer and mode control pair
// Assumes: one 125 MHz clock, serial link sampled synchronously on that clock
// Notes: addresses are 7-bit serial register addresses, data is one byte
package mbmc_pkg;

  // ----------------------------------------------------------------------
  // clock and link timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int SCK_HALF_NS = 32;                          // half period of serial clock
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] FRAME_BITS = 5'h10;                // command byte plus data byte

  // ----------------------------------------------------------------------
  // device register addresses
  // ----------------------------------------------------------------------
  localparam logic [6:0] ADDR_BUF_PORT = 7'h00;
  localparam logic [6:0] ADDR_OP_MODE = 7'h01;
  localparam logic [6:0] ADDR_FRF_HI = 7'h06;
  localparam logic [6:0] ADDR_FRF_MID = 7'h07;
  localparam logic [6:0] ADDR_FRF_LO = 7'h08;
  localparam logic [6:0] ADDR_ACC_PTR = 7'h0d;
  localparam logic [6:0] ADDR_TX_START = 7'h0e;
  localparam logic [6:0] ADDR_RX_START = 7'h0f;
  localparam logic [6:0] ADDR_LAST_START = 7'h10;
  localparam logic [6:0] ADDR_RX_COUNT = 7'h13;
  localparam logic [6:0] ADDR_HDR_CFG = 7'h1d;
  localparam logic [6:0] ADDR_TX_LEN = 7'h22;
  localparam logic [6:0] ADDR_DR_OFFSET = 7'h27;
  localparam logic [6:0] ADDR_FEI_HI = 7'h28;
  localparam logic [6:0] ADDR_FEI_MID = 7'h29;
  localparam logic [6:0] ADDR_FEI_LO = 7'h2a;

  // ----------------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------------
  localparam int MODE_SPREAD_BIT = 7;
  localparam int HDR_IMPLICIT_BIT = 0;
  localparam logic [7:0] RX_START_RST = 8'h00;
  localparam logic [7:0] TX_START_RST = 8'h80;
  localparam logic [7:0] TX_LEN_RST = 8'h01;
  localparam logic [23:0] FRF_RST = 24'h000000;

  // ----------------------------------------------------------------------
  // host register offsets (byte addresses on the bus)
  // ----------------------------------------------------------------------
  localparam logic [11:0] HOST_CMD_OFS = 12'h000;
  localparam logic [11:0] HOST_STAT_OFS = 12'h004;

  // operating modes as written into the mode field
  typedef enum logic [2:0] {
    MODE_SLEEP = 3'h0,
    MODE_STANDBY = 3'h1,
    MODE_FSTX = 3'h2,
    MODE_TX = 3'h3,
    MODE_FSRX = 3'h4,
    MODE_CONT_RX = 3'h5,
    MODE_SINGLE_RX = 3'h6,
    MODE_CAD = 3'h7
  } mbmc_mode_e;

endpackage

// ### logic/mbmc_spi_if.sv
// Purpose: serial register link between host controller and modem device
// Assumes: every signal is sampled on the common mclk
// Notes: miso is valid only while misoOe is high
`timescale 1ns/1ps
`default_nettype none
interface mbmc_spi_if;
  logic sck;
  logic csN;
  logic mosi;
  logic miso;
  logic misoOe;
  modport dev (input sck, input csN, input mosi, output miso, output misoOe);
  modport host (output sck, output csN, output mosi, input miso, input misoOe);
endinterface
`default_nettype wire

// ### logic/mbmc_device.sv
// Purpose: modem side: packet RAM, region pointers, mode control, freq regs
// Assumes: serial link sampled on mclk; frames are command byte then data
// Notes: bursts advance the address except at the buffer data port
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module mbmc_device (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // serial register link
  mbmc_spi_if.dev bus,
  // receive stream from the demodulator
  input wire logic rxStart,
  input wire logic rxByteValid,
  input wire logic [7:0] rxByte,
  input wire logic rxHdrValid,
  input wire logic [7:0] rxHdrLen,
  input wire logic rxEnd,
  input wire logic feiValid,
  input wire logic [19:0] feiIn,
  input wire logic cadDone,
  // transmit stream to the modulator
  output logic [7:0] txData,
  output logic txValid,
  input wire logic txReady,
  output logic txDone,
  // settings seen by the radio
  output mbmc_pkg::mbmc_mode_e mode,
  output logic spreadSel,
  output logic implicitHdr,
  output logic [23:0] carrierWord,
  output logic [7:0] dataRateOffset
);
  import mbmc_pkg::*;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [255:0][7:0] mem;
    logic [7:0] txStart;
    logic [7:0] rxStart;
    logic [7:0] accPtr;
    logic [7:0] lastStart;
    logic [7:0] rxCount;
    logic [7:0] rxWr;
    logic [7:0] txLen;
    logic [7:0] txPtr;
    logic [7:0] txLeft;
    logic [7:0] drOffset;
    logic [23:0] frf;
    logic [19:0] fei;
    logic implicit;
    logic spread;
    mbmc_mode_e mode;
    logic [7:0] txData;
    logic txValid;
    logic txDone;
    logic sckPrev;
    logic [2:0] bitCnt;
    logic first;
    logic wnr;
    logic [6:0] addr;
    logic [7:0] mosiSh;
    logic [7:0] misoSh;
    logic misoOe;
    logic loaded;
  } mbmc_dev_s;

  mbmc_dev_s q;
  mbmc_dev_s d;

  // receive modes share the receive write pointer
  function automatic logic isRx(mbmc_mode_e m);
    isRx = (m == MODE_CONT_RX) || (m == MODE_SINGLE_RX);
  endfunction

  // read decode; buffer reads blocked when not accessible
  function automatic logic [7:0] regRead(mbmc_dev_s s, logic [6:0] a, logic ok);
    unique case (a)
      ADDR_BUF_PORT: regRead = ok ? s.mem[s.accPtr] : 8'h00;
      ADDR_OP_MODE: regRead = {s.spread, 4'h0, s.mode};
      ADDR_FRF_HI: regRead = s.frf[23:16];
      ADDR_FRF_MID: regRead = s.frf[15:8];
      ADDR_FRF_LO: regRead = s.frf[7:0];
      ADDR_ACC_PTR: regRead = s.accPtr;
      ADDR_TX_START: regRead = s.txStart;
      ADDR_RX_START: regRead = s.rxStart;
      ADDR_LAST_START: regRead = s.lastStart;
      ADDR_RX_COUNT: regRead = s.rxCount;
      ADDR_HDR_CFG: regRead = {7'h00, s.implicit};
      ADDR_TX_LEN: regRead = s.txLen;
      ADDR_DR_OFFSET: regRead = s.drOffset;
      ADDR_FEI_HI: regRead = {4'h0, s.fei[19:16]};
      ADDR_FEI_MID: regRead = s.fei[15:8];
      ADDR_FEI_LO: regRead = s.fei[7:0];
      default: regRead = 8'h00;
    endcase
  endfunction

  logic sckRise;
  logic sckFall;
  logic bufOk;
  logic cfgOk;
  logic wrEn;
  logic rdEn;
  logic [6:0] rdAddr;
  logic [7:0] sh;
  logic advRd;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    d = q;
    d.txDone = 1'b0;
    sckRise = bus.sck & ~q.sckPrev;
    sckFall = ~bus.sck & q.sckPrev;
    d.sckPrev = bus.sck;
    bufOk = q.spread && (q.mode != MODE_SLEEP);
    cfgOk = (q.mode == MODE_SLEEP) || (q.mode == MODE_STANDBY);
    wrEn = 1'b0;
    rdEn = 1'b0;
    rdAddr = q.addr;
    advRd = 1'b0;
    sh = {q.mosiSh[6:0], bus.mosi};

    // serial frame: shift in on rise, present read data on fall
    if (bus.csN) begin
      d.bitCnt = 3'h0;
      d.first = 1'b1;
      d.misoOe = 1'b0;
      d.loaded = 1'b0;
    end else begin
      d.misoOe = 1'b1;
      if (sckFall) begin
        // freshly loaded byte keeps its msb for one more bit time
        if (q.loaded) begin
          d.loaded = 1'b0;
        end else begin
          d.misoSh = {q.misoSh[6:0], 1'b0};
        end
      end
      if (sckRise) begin
        d.mosiSh = sh;
        d.bitCnt = 3'(q.bitCnt + 3'h1);
        // first bit of a data slot: the fetched byte is really being sent now
        if (!q.first && !q.wnr && (q.bitCnt == 3'h0) && bufOk &&
            (q.addr == ADDR_BUF_PORT)) begin
          advRd = 1'b1;
        end
        if (q.bitCnt == 3'h7) begin
          if (q.first) begin
            d.first = 1'b0;
            d.wnr = sh[7];
            d.addr = sh[6:0];
            rdEn = ~sh[7];
            rdAddr = sh[6:0];
          end else begin
            wrEn = q.wnr;
            // the data port keeps its address so a burst streams the RAM
            d.addr = (q.addr == ADDR_BUF_PORT) ? q.addr : 7'(q.addr + 7'h01);
            rdEn = ~q.wnr;
            rdAddr = d.addr;
          end
        end
      end
    end

    // read fetch; the prefetch at a byte's end must not move the pointer,
    // or a single-byte frame would skip a location
    if (rdEn) begin
      d.misoSh = regRead(q, rdAddr, bufOk);
      d.loaded = 1'b1;
    end
    if (advRd) begin
      d.accPtr = 8'(q.accPtr + 8'h01);
    end

    // transmit: one byte per handshake from the transmit region
    if (q.mode == MODE_TX) begin
      if (!q.txValid || txReady) begin
        if (q.txLeft != 8'h00) begin
          d.txData = q.mem[q.txPtr];
          d.txValid = 1'b1;
          d.txPtr = 8'(q.txPtr + 8'h01);
          d.txLeft = 8'(q.txLeft - 8'h01);
        end else begin
          d.txValid = 1'b0;
          d.txDone = 1'b1;
          d.mode = MODE_STANDBY;
        end
      end
    end else begin
      d.txValid = 1'b0;
    end

    // receive: bytes land in order, no bound at the region end
    if (isRx(q.mode) && q.spread) begin
      if (rxStart) begin
        d.lastStart = q.rxWr;
      end
      if (rxHdrValid && !q.implicit) begin
        d.rxCount = rxHdrLen;
      end
      if (rxByteValid) begin
        // stored whatever the checksum later says
        d.mem[q.rxWr] = rxByte;
        d.rxWr = 8'(q.rxWr + 8'h01);
      end
      if (feiValid) begin
        d.fei = feiIn;
      end
      if (rxEnd && (q.mode == MODE_SINGLE_RX)) begin
        d.mode = MODE_STANDBY;
      end
    end
    if ((q.mode == MODE_CAD) && cadDone) begin
      d.mode = MODE_STANDBY;
    end

    // register writes; a host mode write overrides an automatic return
    if (wrEn) begin
      unique case (q.addr)
        ADDR_BUF_PORT: begin
          if (bufOk) begin
            d.mem[q.accPtr] = sh;
            d.accPtr = 8'(q.accPtr + 8'h01);
          end
        end
        ADDR_OP_MODE: begin
          d.mode = mbmc_mode_e'(sh[2:0]);
          if (q.mode == MODE_SLEEP) begin
            d.spread = sh[MODE_SPREAD_BIT];
          end
        end
        ADDR_ACC_PTR: d.accPtr = sh;
        ADDR_TX_START: if (cfgOk) d.txStart = sh;
        ADDR_RX_START: if (cfgOk) d.rxStart = sh;
        ADDR_TX_LEN: if (cfgOk) d.txLen = sh;
        ADDR_HDR_CFG: if (cfgOk) d.implicit = sh[HDR_IMPLICIT_BIT];
        ADDR_FRF_HI: if (cfgOk) d.frf[23:16] = sh;
        ADDR_FRF_MID: if (cfgOk) d.frf[15:8] = sh;
        ADDR_FRF_LO: if (cfgOk) d.frf[7:0] = sh;
        ADDR_DR_OFFSET: if (cfgOk) d.drOffset = sh;
        default: begin
        end
      endcase
    end

    // mode entry actions
    if ((d.mode == MODE_TX) && (q.mode != MODE_TX)) begin
      d.txPtr = q.txStart;
      d.txLeft = d.txLen;
    end
    // continuous receive never rewinds while it stays selected
    if (isRx(d.mode) && !isRx(q.mode)) begin
      d.rxWr = q.rxStart;
    end
    // only sleep wipes the RAM; other changes leave it alone
    if ((d.mode == MODE_SLEEP) && (q.mode != MODE_SLEEP)) begin
      d.mem = '0;
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.rxStart <= RX_START_RST;
      q.txStart <= TX_START_RST;
      q.txLen <= TX_LEN_RST;
      q.frf <= FRF_RST;
      q.mode <= MODE_STANDBY;
      q.first <= 1'b1;
      q.sckPrev <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state flops
  assign bus.miso = q.misoSh[7];
  assign bus.misoOe = q.misoOe;
  assign txData = q.txData;
  assign txValid = q.txValid;
  assign txDone = q.txDone;
  assign mode = q.mode;
  assign spreadSel = q.spread;
  assign implicitHdr = q.implicit;
  assign carrierWord = q.frf;
  assign dataRateOffset = q.drOffset;

endmodule
`default_nettype wire

// ### logic/mbmc_host.sv
// Purpose: host controller: APB command registers driving the serial link
// Assumes: one byte per frame; software sequences bursts itself
// Notes: the half period of sck must stay at two cycles or more
`timescale 1ns/1ps
`default_nettype none
module mbmc_host #(
  parameter int SCK_HALF = mbmc_pkg::SCK_HALF_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial register link
  mbmc_spi_if.host bus
);
  import mbmc_pkg::*;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    H_IDLE = 2'b01,
    H_XFER = 2'b10
  } mbmc_hst_e;

  typedef struct packed {
    mbmc_hst_e st;
    logic [7:0] cnt;
    logic [4:0] bitCnt;
    logic [15:0] sh;
    logic [7:0] rxSh;
    logic [7:0] rdData;
    logic sck;
    logic csN;
    logic mosi;
    logic rdy;
    logic [31:0] prdata;
    logic pslverr;
  } mbmc_hst_s;

  mbmc_hst_s q;
  mbmc_hst_s d;
  logic start;
  logic [7:0] halfLast;

  assign halfLast = 8'(SCK_HALF - 1);

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    d = q;
    // one wait state keeps pready a flop output
    if (psel && penable && !q.rdy) begin
      d.rdy = 1'b1;
      d.pslverr = !((paddr == HOST_CMD_OFS) || (paddr == HOST_STAT_OFS));
      d.prdata = ((paddr == HOST_STAT_OFS) && !pwrite) ?
        {16'h0000, q.rdData, 7'h00, (q.st == H_XFER)} : 32'h00000000;
    end else begin
      d.rdy = 1'b0;
    end
    // commands while busy are dropped; software polls busy first
    start = psel && penable && q.rdy && pwrite && (paddr == HOST_CMD_OFS) && (q.st == H_IDLE);

    unique case (q.st)
      H_IDLE: begin
        if (start) begin
          d.sh = {pwdata[7:0], pwdata[15:8]};
          d.mosi = pwdata[7];
          d.csN = 1'b0;
          d.cnt = 8'h00;
          d.bitCnt = 5'h00;
          d.st = H_XFER;
        end
      end
      H_XFER: begin
        if (q.cnt == halfLast) begin
          d.cnt = 8'h00;
          if (!q.sck) begin
            if (q.bitCnt == FRAME_BITS) begin
              d.csN = 1'b1;
              d.mosi = 1'b0;
              d.rdData = q.rxSh;
              d.st = H_IDLE;
            end else begin
              // sample miso as sck rises; device moved it a half period ago
              d.sck = 1'b1;
              d.rxSh = {q.rxSh[6:0], bus.miso};
            end
          end else begin
            d.sck = 1'b0;
            d.bitCnt = 5'(q.bitCnt + 5'h01);
            d.sh = {q.sh[14:0], 1'b0};
            d.mosi = q.sh[14];
          end
        end else begin
          d.cnt = 8'(q.cnt + 8'h01);
        end
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.st <= H_IDLE;
      q.csN <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.rdy;
  assign pslverr = q.pslverr;
  assign bus.sck = q.sck;
  assign bus.csN = q.csN;
  assign bus.mosi = q.mosi;

endmodule
`default_nettype wire

// ### sim/mbmc_sva.sv
// Purpose: timing checks on the serial link, host bus and radio handshakes
// Assumes: one clock domain, asynchronous active-low reset
// Notes: watches design outputs plus psel, penable, txReady and rxEnd driven by the testbench
`timescale 1ns/1ps
`default_nettype none
module mbmc_sva (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // serial link
  input wire logic sck,
  input wire logic csN,
  input wire logic misoOe,
  // host bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // radio side
  input wire mbmc_pkg::mbmc_mode_e mode,
  input wire logic txValid,
  input wire logic txReady,
  input wire logic [7:0] txData,
  input wire logic txDone,
  input wire logic rxEnd
);
  import mbmc_pkg::*;
  // ------------------------------------------------------------------
  // clocking and bus phases
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence apbSetup;
    psel && !penable;
  endsequence
  sequence apbAccess;
    psel && penable;
  endsequence
  // link framing: sck parked low, enable follows select, gap of two cycles
  sck_idle_a: assert property (csN |-> !sck)
    else $error("serial clock moved outside a frame");
  oe_follow_a: assert property ($fell(csN) |-> ##[1:2] misoOe)
    else $error("data enable late after frame start");
  frame_gap_a: assert property ($rose(csN) |=> csN)
    else $error("frame select gap shorter than two cycles");
  // exactly one wait state, ready lasts one cycle
  wait_state_a: assert property (apbSetup ##1 apbAccess |-> !pready ##1 pready)
    else $error("bus answer not after one wait state");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("bus ready held longer than one cycle");
  // stream held while stalled; only in transmit mode
  tx_hold_a: assert property (txValid && !txReady |=> txValid && $stable(txData))
    else $error("transmit byte dropped while stalled");
  tx_mode_a: assert property (txValid |-> mode == MODE_TX)
    else $error("transmit valid outside transmit mode");
  tx_done_a: assert property (txDone |-> mode == MODE_STANDBY && $past(mode) == MODE_TX)
    else $error("no return to standby after transmit");
  single_end_a: assert property (rxEnd && mode == MODE_SINGLE_RX |=> mode == MODE_STANDBY)
    else $error("single receive did not end in standby");
  cont_stay_a: assert property (rxEnd && mode == MODE_CONT_RX |=> mode == MODE_CONT_RX)
    else $error("continuous receive left its mode");
endmodule
`default_nettype wire

// ### sim/tb_top.sv
// Purpose: drives both ends through the host bus and the radio streams
// Assumes: default serial half period, single-byte frames only
// Notes: device registers reached by command then busy polling
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import mbmc_pkg::*;
  logic mclk = 1'h0;
  logic txReady = 1'h0;
  logic arst_n, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic rxStart, rxByteValid, rxHdrValid, rxEnd, feiValid, cadDone;
  logic txValid, txDone, spreadSel, implicitHdr;
  logic [7:0] rxByte, rxHdrLen, txData, dataRateOffset;
  logic [19:0] feiIn;
  logic [23:0] carrierWord;
  mbmc_mode_e mode;
  mbmc_mode_e ml[4] = '{MODE_FSTX, MODE_FSRX, MODE_CONT_RX, MODE_CAD};
  logic [7:0] txQ[$];
  int errors, num_checks, cycles;
  mbmc_spi_if spi();
  mbmc_device i_mbmc_device (.mclk, .arst_n, .bus(spi), .rxStart, .rxByteValid, .rxByte,
    .rxHdrValid, .rxHdrLen, .rxEnd, .feiValid, .feiIn, .cadDone, .txData, .txValid,
    .txReady, .txDone, .mode, .spreadSel, .implicitHdr, .carrierWord, .dataRateOffset);
  mbmc_host i_mbmc_host (.mclk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .bus(spi));
  mbmc_sva u_sva (.mclk, .arst_n, .sck(spi.sck), .csN(spi.csN), .misoOe(spi.misoOe),
    .psel, .penable, .pready, .mode, .txValid, .txReady, .txData, .txDone, .rxEnd);
  // ------------------------------------------------------------------
  // clock, stalling sink, hang guard
  // ------------------------------------------------------------------
  always #4 mclk = ~mclk;
  // sink stalls every other cycle so held bytes get exercised
  always @(posedge mclk) begin
    txReady <= ~txReady;
    if (txValid && txReady) txQ.push_back(txData);
    cycles++;
    if (cycles == 40000) begin
      errors++;
      report_and_stop();
    end
  end
  // ------------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask
  // setup, access, then hold until ready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do @(posedge mclk); while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // a new command while busy is dropped, so always wait out the frame
  task automatic dw(input logic [6:0] a, input logic [7:0] d);
    apb(1'h1, HOST_CMD_OFS, {16'h0000, d, 1'h1, a});
    do apb(1'h0, HOST_STAT_OFS, 32'h0); while (r[0] !== 1'h0);
  endtask
  task automatic cr(input string n, input logic [6:0] a, input logic [7:0] x);
    apb(1'h1, HOST_CMD_OFS, {25'h0, a});
    do apb(1'h0, HOST_STAT_OFS, 32'h0); while (r[0] !== 1'h0);
    chk(n, r[15:8], x);
  endtask
  // one received packet: start, header length, payload, end
  task automatic rxpkt(input logic [7:0] n);
    @(posedge mclk);
    rxStart <= 1'h1;
    feiValid <= 1'h1;
    feiIn <= 20'h81234;
    @(posedge mclk);
    rxStart <= 1'h0;
    feiValid <= 1'h0;
    rxHdrValid <= 1'h1;
    rxHdrLen <= n;
    @(posedge mclk);
    rxHdrValid <= 1'h0;
    for (int i = 0; i < n; i++) begin
      rxByteValid <= 1'h1;
      rxByte <= 8'hb0 + i[7:0];
      @(posedge mclk);
    end
    rxByteValid <= 1'h0;
    rxEnd <= 1'h1;
    @(posedge mclk);
    rxEnd <= 1'h0;
    @(posedge mclk);
  endtask
  // ------------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------------
  initial begin
    {arst_n, psel, penable, pwrite, paddr, pwdata, cadDone} = '0;
    {rxStart, rxByteValid, rxByte, rxHdrValid, rxHdrLen, rxEnd, feiValid, feiIn} = '0;
    repeat (3) @(posedge mclk);
    arst_n <= 1'h1;
    cr("rx start rst", ADDR_RX_START, 8'h00);
    cr("tx start rst", ADDR_TX_START, 8'h80);
    cr("mode rst", ADDR_OP_MODE, 8'h01);
    apb(1'h0, 12'h008, 32'h0);
    chk("unmapped", {e, r[30:0]}, 32'h80000000);
    // buffer closed while the spread modem is off
    dw(ADDR_ACC_PTR, 8'h00);
    dw(ADDR_BUF_PORT, 8'haa);
    dw(ADDR_ACC_PTR, 8'h00);
    cr("buf no spread", ADDR_BUF_PORT, 8'h00);
    dw(ADDR_OP_MODE, 8'h81);
    chk("spread awake", spreadSel, 1'h0);
    dw(ADDR_OP_MODE, 8'h80);
    dw(ADDR_OP_MODE, 8'h81);
    chk("spread kept", spreadSel, 1'h1);
    // burst across the top of the ram
    dw(ADDR_ACC_PTR, 8'hfe);
    for (int i = 0; i < 3; i++) dw(ADDR_BUF_PORT, 8'ha0 + i[7:0]);
    cr("ptr wrap", ADDR_ACC_PTR, 8'h01);
    dw(ADDR_ACC_PTR, 8'hfe);
    for (int i = 0; i < 3; i++) cr("burst", ADDR_BUF_PORT, 8'ha0 + i[7:0]);
    foreach (ml[i]) begin
      dw(ADDR_OP_MODE, {5'h10, ml[i]});
      chk("mode", mode, ml[i]);
      if (ml[i] == MODE_FSRX) begin
        dw(ADDR_TX_START, 8'h11);
        cr("cfg refused", ADDR_TX_START, 8'h80);
      end
    end
    @(posedge mclk);
    cadDone <= 1'h1;
    @(posedge mclk);
    cadDone <= 1'h0;
    @(posedge mclk);
    chk("cad end", mode, MODE_STANDBY);
    dw(ADDR_TX_START, 8'h00);
    dw(ADDR_RX_START, 8'h00);
    cr("tx zero", ADDR_TX_START, 8'h00);
    cr("rx zero", ADDR_RX_START, 8'h00);
    // receive near the region border so it spills into transmit space
    dw(ADDR_RX_START, 8'h7e);
    dw(ADDR_OP_MODE, 8'h85);
    rxpkt(8'h04);
    chk("cont mode", mode, MODE_CONT_RX);
    cr("rx count", ADDR_RX_COUNT, 8'h04);
    cr("last start", ADDR_LAST_START, 8'h7e);
    cr("fei hi", ADDR_FEI_HI, 8'h08);
    cr("fei mid", ADDR_FEI_MID, 8'h12);
    cr("fei lo", ADDR_FEI_LO, 8'h34);
    dw(ADDR_OP_MODE, 8'h86);
    rxpkt(8'h01);
    chk("single end", mode, MODE_STANDBY);
    cr("last start 2", ADDR_LAST_START, 8'h82);
    dw(ADDR_ACC_PTR, 8'h7e);
    for (int i = 0; i < 5; i++) cr("rx data", ADDR_BUF_PORT, 8'hb0 + i[7:0] % 8'h04);
    dw(ADDR_HDR_CFG, 8'h01);
    chk("implicit", implicitHdr, 1'h1);
    dw(ADDR_OP_MODE, 8'h85);
    rxpkt(8'h02);
    dw(ADDR_OP_MODE, 8'h81);
    cr("count kept", ADDR_RX_COUNT, 8'h01);
    // resend what was received, from the same place
    dw(ADDR_TX_START, 8'h7e);
    dw(ADDR_TX_LEN, 8'h03);
    txQ.delete();
    dw(ADDR_OP_MODE, 8'h83);
    // the stalling sink may still be taking the last byte as the frame ends
    repeat (8) @(posedge mclk);
    chk("tx count", txQ.size(), 3);
    foreach (txQ[i]) chk("tx byte", txQ[i], 8'hb0 + i[7:0]);
    chk("tx end", mode, MODE_STANDBY);
    dw(ADDR_FRF_HI, 8'h12);
    dw(ADDR_FRF_MID, 8'h34);
    dw(ADDR_FRF_LO, 8'h56);
    chk("carrier", carrierWord, 24'h123456);
    dw(ADDR_DR_OFFSET, 8'hf3);
    chk("offset", dataRateOffset, 8'hf3);
    cr("offset rd", ADDR_DR_OFFSET, 8'hf3);
    // sleep wipes the ram but not the settings
    dw(ADDR_OP_MODE, 8'h80);
    cr("cfg asleep", ADDR_RX_START, 8'h7e);
    cr("buf asleep", ADDR_BUF_PORT, 8'h00);
    dw(ADDR_OP_MODE, 8'h81);
    dw(ADDR_ACC_PTR, 8'h7e);
    cr("ram wiped", ADDR_BUF_PORT, 8'h00);
    report_and_stop();
  end
endmodule
`default_nettype wire
